/* File: pkg/ufc_defs.vh */
`ifndef UFC_DEFS_VH
`define UFC_DEFS_VH

// Register offsets on the plain register port
`define UFC_ADDR_DATA 3'h0
`define UFC_ADDR_FIFO_CONTROL 3'h1
`define UFC_ADDR_STATUS 3'h2
`define UFC_ADDR_INT_STATUS 3'h3
`define UFC_ADDR_INT_MASK 3'h4
`define UFC_ADDR_ALT_FUNCTION 3'h5

// fifo_control fields
`define UFC_FC_ENABLE 0
`define UFC_FC_RX_FLUSH 1
`define UFC_FC_TX_FLUSH 2
`define UFC_FC_DMA_MODE 3
`define UFC_FC_THR_LO 6
`define UFC_FC_THR_HI 7
`define UFC_FC_RESET 8'h00

// rx_threshold_sel encodings and levels
`define UFC_THR_SEL_1 2'h0
`define UFC_THR_SEL_4 2'h1
`define UFC_THR_SEL_8 2'h2
`define UFC_THR_SEL_14 2'h3
`define UFC_THR_LVL_1 5'h01
`define UFC_THR_LVL_4 5'h04
`define UFC_THR_LVL_8 5'h08
`define UFC_THR_LVL_14 5'h0E

// alt_function_select: bits 2:1 pick the multi_function_pin use
`define UFC_AF_SEL_LO 1
`define UFC_AF_SEL_HI 2
`define UFC_AF_RX_READY 2'h1
`define UFC_AF_RESET 8'h00

// Interrupt status / mask bits
`define UFC_IRQ_RX_THR 0
`define UFC_IRQ_RX_TIMEOUT 1
`define UFC_IRQ_TX_EMPTY 2
`define UFC_IRQ_RX_OVERRUN 3
`define UFC_IRQ_W 4
`define UFC_IRQ_MASK_RESET 4'h0

`endif

/* File: design/ufc_top.v */
// Local design decisions: the register offsets and the plain strobed port.
`include "ufc_defs.vh"
`default_nettype none
module ufc_top #(
    parameter DEPTH_LOG2 = 4,
    parameter WIDTH = 8
) (
    input wire clk,
    input wire reset,
    input wire [2:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata_ff,
    input wire tx_pull,
    output reg [WIDTH-1:0] tx_char_ff,
    output reg tx_char_valid_ff,
    input wire rx_push,
    input wire [WIDTH-1:0] rx_char,
    input wire rx_timeout,
    output reg tx_space_avail_n_ff,
    output reg multi_function_pin_ff,
    output reg irq_ff
);
    localparam DEPTH = 1 << DEPTH_LOG2;
    localparam [DEPTH_LOG2:0] DEPTH_CNT = DEPTH;
    localparam [DEPTH_LOG2:0] ONE_CNT = 1;

    function [DEPTH_LOG2:0] thr_level;
        input [1:0] sel;
        begin
            case (sel)
                `UFC_THR_SEL_1: thr_level = `UFC_THR_LVL_1;
                `UFC_THR_SEL_4: thr_level = `UFC_THR_LVL_4;
                `UFC_THR_SEL_8: thr_level = `UFC_THR_LVL_8;
                `UFC_THR_SEL_14: thr_level = `UFC_THR_LVL_14;
                default: thr_level = `UFC_THR_LVL_1;
            endcase
        end
    endfunction

    reg [WIDTH-1:0] tx_mem [0:DEPTH-1];
    reg [WIDTH-1:0] rx_mem [0:DEPTH-1];
    reg [DEPTH_LOG2-1:0] tx_rd_ff, tx_wr_ff, rx_rd_ff, rx_wr_ff;
    reg [DEPTH_LOG2:0] tx_cnt_ff, rx_cnt_ff;
    reg [7:0] fc_ff;
    reg [7:0] af_ff;
    reg [`UFC_IRQ_W-1:0] int_stat_ff, int_mask_ff;
    reg rx_blk_ff;

    reg [7:0] nxt_fc;
    reg tx_flush, rx_flush;
    reg [DEPTH_LOG2:0] cap;
    reg tx_push, tx_pop, rx_push_ok, rx_pop;
    reg [DEPTH_LOG2:0] nxt_tx_cnt, nxt_rx_cnt;
    reg [`UFC_IRQ_W-1:0] ev, nxt_int_stat;
    reg nxt_rx_blk;
    reg [7:0] nxt_rdata;
    wire fifo_en = fc_ff[`UFC_FC_ENABLE];
    wire [DEPTH_LOG2:0] thr = thr_level(fc_ff[`UFC_FC_THR_HI:`UFC_FC_THR_LO]);
    wire fc_wr = reg_wr && (reg_addr == `UFC_ADDR_FIFO_CONTROL);

    always @* begin
        nxt_fc = fc_ff;
        tx_flush = 1'b0;
        rx_flush = 1'b0;
        if (fc_wr) begin
            if (reg_wdata[`UFC_FC_ENABLE]) begin
                // Flush bits never stored: they read back as zero
                nxt_fc = reg_wdata & 8'hC9;
                tx_flush = reg_wdata[`UFC_FC_TX_FLUSH];
                rx_flush = reg_wdata[`UFC_FC_RX_FLUSH];
            end else begin
                nxt_fc = fc_ff & 8'hFE;
            end
        end
    end

    always @* begin
        // With FIFOs off each side acts as a one-character holding register
        cap = fifo_en ? DEPTH_CNT : ONE_CNT;
        tx_push = reg_wr && (reg_addr == `UFC_ADDR_DATA) && (tx_cnt_ff < cap);
        tx_pop = tx_pull && (tx_cnt_ff != 0);
        rx_push_ok = rx_push && (rx_cnt_ff < cap);
        rx_pop = reg_rd && (reg_addr == `UFC_ADDR_DATA) && (rx_cnt_ff != 0);
        nxt_tx_cnt = tx_cnt_ff + {{DEPTH_LOG2{1'b0}}, tx_push} - {{DEPTH_LOG2{1'b0}}, tx_pop};
        nxt_rx_cnt = rx_cnt_ff + {{DEPTH_LOG2{1'b0}}, rx_push_ok} - {{DEPTH_LOG2{1'b0}}, rx_pop};
        if (tx_flush) begin
            nxt_tx_cnt = {(DEPTH_LOG2+1){1'b0}};
        end
        if (rx_flush) begin
            nxt_rx_cnt = {(DEPTH_LOG2+1){1'b0}};
        end
        ev = {`UFC_IRQ_W{1'b0}};
        ev[`UFC_IRQ_RX_THR] = rx_push_ok && !rx_flush && (nxt_rx_cnt == thr);
        ev[`UFC_IRQ_RX_TIMEOUT] = rx_timeout;
        ev[`UFC_IRQ_TX_EMPTY] = tx_pop && (nxt_tx_cnt == 0);
        ev[`UFC_IRQ_RX_OVERRUN] = rx_push && !rx_push_ok;
        nxt_int_stat = int_stat_ff;
        if (reg_rd && (reg_addr == `UFC_ADDR_INT_STATUS)) begin
            nxt_int_stat = {`UFC_IRQ_W{1'b0}};
        end
        // Set wins over the read-clear so no event is lost
        nxt_int_stat = nxt_int_stat | ev;
        // Block-mode rx ready: latched, released only on empty
        if (nxt_rx_cnt == 0) begin
            nxt_rx_blk = 1'b0;
        end else if ((nxt_rx_cnt >= thr) || rx_timeout) begin
            nxt_rx_blk = 1'b1;
        end else begin
            nxt_rx_blk = rx_blk_ff;
        end
    end

    always @* begin
        case (reg_addr)
            `UFC_ADDR_DATA: nxt_rdata = (rx_cnt_ff != 0) ? rx_mem[rx_rd_ff] : 8'h00;
            `UFC_ADDR_FIFO_CONTROL: nxt_rdata = fc_ff;
            `UFC_ADDR_STATUS: nxt_rdata = {tx_cnt_ff[3:0], rx_cnt_ff[3:0]};
            `UFC_ADDR_INT_STATUS: nxt_rdata = {4'h0, int_stat_ff};
            `UFC_ADDR_INT_MASK: nxt_rdata = {4'h0, int_mask_ff};
            `UFC_ADDR_ALT_FUNCTION: nxt_rdata = af_ff;
            default: nxt_rdata = 8'h00;
        endcase
    end

    // Storage has no reset; counters and pointers define validity
    always @(posedge clk) begin
        if (tx_push) begin
            tx_mem[tx_wr_ff] <= reg_wdata[WIDTH-1:0];
        end
        if (rx_push_ok) begin
            rx_mem[rx_wr_ff] <= rx_char;
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            fc_ff <= `UFC_FC_RESET;
            af_ff <= `UFC_AF_RESET;
            int_mask_ff <= `UFC_IRQ_MASK_RESET;
            int_stat_ff <= {`UFC_IRQ_W{1'b0}};
            tx_rd_ff <= {DEPTH_LOG2{1'b0}};
            tx_wr_ff <= {DEPTH_LOG2{1'b0}};
            rx_rd_ff <= {DEPTH_LOG2{1'b0}};
            rx_wr_ff <= {DEPTH_LOG2{1'b0}};
            tx_cnt_ff <= {(DEPTH_LOG2+1){1'b0}};
            rx_cnt_ff <= {(DEPTH_LOG2+1){1'b0}};
            rx_blk_ff <= 1'b0;
            reg_rdata_ff <= 8'h00;
            tx_char_ff <= {WIDTH{1'b0}};
            tx_char_valid_ff <= 1'b0;
            tx_space_avail_n_ff <= 1'b0;
            multi_function_pin_ff <= 1'b1;
            irq_ff <= 1'b0;
        end else begin
            fc_ff <= nxt_fc;
            if (reg_wr && (reg_addr == `UFC_ADDR_ALT_FUNCTION)) begin
                af_ff <= reg_wdata;
            end
            if (reg_wr && (reg_addr == `UFC_ADDR_INT_MASK)) begin
                int_mask_ff <= reg_wdata[`UFC_IRQ_W-1:0];
            end
            int_stat_ff <= nxt_int_stat;
            irq_ff <= |(nxt_int_stat & int_mask_ff);
            reg_rdata_ff <= reg_rd ? nxt_rdata : 8'h00;
            tx_cnt_ff <= nxt_tx_cnt;
            rx_cnt_ff <= nxt_rx_cnt;
            // Flush resets pointers; the shift registers outside are untouched
            if (tx_flush) begin
                tx_rd_ff <= {DEPTH_LOG2{1'b0}};
                tx_wr_ff <= {DEPTH_LOG2{1'b0}};
            end else begin
                if (tx_push) begin
                    tx_wr_ff <= tx_wr_ff + 1'b1;
                end
                if (tx_pop) begin
                    tx_rd_ff <= tx_rd_ff + 1'b1;
                end
            end
            if (rx_flush) begin
                rx_rd_ff <= {DEPTH_LOG2{1'b0}};
                rx_wr_ff <= {DEPTH_LOG2{1'b0}};
            end else begin
                if (rx_push_ok) begin
                    rx_wr_ff <= rx_wr_ff + 1'b1;
                end
                if (rx_pop) begin
                    rx_rd_ff <= rx_rd_ff + 1'b1;
                end
            end
            tx_char_valid_ff <= tx_pop;
            if (tx_pop) begin
                tx_char_ff <= tx_mem[tx_rd_ff];
            end
            rx_blk_ff <= nxt_rx_blk;
            // Ready outputs follow the state after this edge's updates; pin routing uses alt_function_select as held before this edge
            if (nxt_fc[`UFC_FC_ENABLE] && nxt_fc[`UFC_FC_DMA_MODE]) begin
                tx_space_avail_n_ff <= (nxt_tx_cnt == DEPTH_CNT);
            end else begin
                tx_space_avail_n_ff <= (nxt_tx_cnt != 0);
            end
            // Pin idles high unless software routes rx ready to it
            if (af_ff[`UFC_AF_SEL_HI:`UFC_AF_SEL_LO] != `UFC_AF_RX_READY) begin
                multi_function_pin_ff <= 1'b1;
            end else if (nxt_fc[`UFC_FC_ENABLE] && nxt_fc[`UFC_FC_DMA_MODE]) begin
                multi_function_pin_ff <= !nxt_rx_blk;
            end else begin
                multi_function_pin_ff <= (nxt_rx_cnt == 0);
            end
        end
    end
endmodule
`default_nettype wire

/* File: test/ufc_top_properties.sv */
`default_nettype none
module ufc_chk (
    input wire logic clk,
    input wire logic reset,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata_ff,
    input wire logic tx_space_avail_n_ff,
    input wire logic multi_function_pin_ff,
    input wire logic irq_ff
);
timeunit 1ns;
timeprecision 1ps;
logic [1:0] alt_ff;
logic mask_ff;
// Shadow of software writes, since the design's copies are not ports
always @(posedge clk) begin
    if (reset) begin
        alt_ff <= 2'h0;
        mask_ff <= 1'h0;
    end else if (reg_wr && reg_addr == 3'h5) begin
        alt_ff <= reg_wdata[2:1];
    end else if (reg_wr && reg_addr == 3'h4) begin
        mask_ff <= |reg_wdata[3:0];
    end
end
chk_flush_bits_zero: assert property (@(posedge clk) disable iff (reset)
    reg_rd && reg_addr == 3'h1 |=> reg_rdata_ff[2:1] == 2'h0) else $error("flush bits stuck");
chk_rx_flush_empty: assert property (@(posedge clk) disable iff (reset)
    (reg_wr && reg_addr == 3'h1 && reg_wdata[1:0] == 2'h3) ##2 (reg_rd && reg_addr == 3'h2)
    |=> reg_rdata_ff[3:0] == 4'h0) else $error("rx not empty after flush");
chk_tx_flush_empty: assert property (@(posedge clk) disable iff (reset)
    (reg_wr && reg_addr == 3'h1 && reg_wdata[2] && reg_wdata[0]) ##2 (reg_rd && reg_addr == 3'h2)
    |=> reg_rdata_ff[7:4] == 4'h0) else $error("tx not empty after flush");
chk_enable_keep: assert property (@(posedge clk) disable iff (reset)
    (reg_rd && reg_addr == 3'h1) ##2 (reg_wr && reg_addr == 3'h1 && !reg_wdata[0]) ##2
    (reg_rd && reg_addr == 3'h1) |=> reg_rdata_ff == ($past(reg_rdata_ff, 4) & 8'hFE))
    else $error("disabled write changed other bits");
chk_reset_outputs: assert property (@(posedge clk) reset |=> multi_function_pin_ff && !irq_ff
    && !tx_space_avail_n_ff && reg_rdata_ff == 8'h00) else $error("outputs not at reset level");
chk_pin_unrouted: assert property (@(posedge clk) disable iff (reset)
    alt_ff != 2'h1 [*3] |-> multi_function_pin_ff) else $error("pin low while not routed");
chk_irq_masked: assert property (@(posedge clk) disable iff (reset)
    !mask_ff [*3] |-> !irq_ff) else $error("irq while fully masked");
chk_tx_flush_ready: assert property (@(posedge clk) disable iff (reset)
    reg_wr && reg_addr == 3'h1 && reg_wdata[2] && reg_wdata[0] |=> !tx_space_avail_n_ff)
    else $error("tx ready not low after flush");
endmodule
bind ufc_top ufc_chk u_chk (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .tx_space_avail_n_ff(tx_space_avail_n_ff),
    .multi_function_pin_ff(multi_function_pin_ff), .irq_ff(irq_ff));
`default_nettype wire

/* File: test/ufc_link_model.sv */
`default_nettype none
module ufc_link_model (
    input wire logic clk,
    input wire logic push_go,
    input wire logic pull_go,
    output logic rx_push,
    output logic [7:0] rx_char,
    output logic tx_pull
);
timeunit 1ns;
timeprecision 1ps;
logic [7:0] seq_ff = 8'hA0;
initial begin
    rx_push = 1'h0;
    rx_char = 8'h00;
    tx_pull = 1'h0;
end
always @(posedge clk) begin
    rx_push <= push_go;
    tx_pull <= pull_go;
    seq_ff <= seq_ff + {7'h00, push_go};
    // Toggle when idle so a stale sample never looks valid
    rx_char <= push_go ? seq_ff : ~rx_char;
end
endmodule
`default_nettype wire

/* File: test/tb.sv */
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; $display("ERROR %0t %0h %0h", $time, a, b); end end
module tb;
timeunit 1ns;
timeprecision 1ps;
logic clk = 1'h0, reset = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, push_go = 1'h0, pull_go = 1'h0, rx_timeout = 1'h0;
logic [2:0] reg_addr = 3'h0;
logic [7:0] reg_wdata = 8'h00, rd_val;
logic [7:0] reg_rdata_ff, tx_char_ff, rx_char;
logic tx_pull, tx_char_valid_ff, rx_push, tx_space_avail_n_ff, multi_function_pin_ff, irq_ff;
int num_errors = 0, checked = 0, cycles = 0, pulls = 0;
ufc_top uut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .tx_pull(tx_pull), .tx_char_ff(tx_char_ff),
    .tx_char_valid_ff(tx_char_valid_ff), .rx_push(rx_push), .rx_char(rx_char), .rx_timeout(rx_timeout),
    .tx_space_avail_n_ff(tx_space_avail_n_ff), .multi_function_pin_ff(multi_function_pin_ff), .irq_ff(irq_ff));
ufc_link_model link (.clk(clk), .push_go(push_go), .pull_go(pull_go), .rx_push(rx_push), .rx_char(rx_char),
    .tx_pull(tx_pull));
initial forever #2 clk = ~clk;
task automatic finish_test;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
endtask
always @(posedge clk) begin
    cycles <= cycles + 1;
    if (tx_char_valid_ff) begin
        pulls <= pulls + 1;
    end
    if (cycles == 20000) begin
        num_errors++;
        finish_test();
    end
end
task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk) begin reg_wr <= 1'h1; reg_addr <= a; reg_wdata <= d; end
    @(posedge clk) reg_wr <= 1'h0;
    #1;
endtask
task automatic rd(input logic [2:0] a);
    @(posedge clk) begin reg_rd <= 1'h1; reg_addr <= a; end
    @(posedge clk) reg_rd <= 1'h0;
    @(negedge clk) rd_val = reg_rdata_ff;
endtask
// Link pushes or pulls n characters, then lets the pins settle
task automatic lk(input int n, input bit pull);
    repeat (n) begin
        @(posedge clk) begin push_go <= !pull; pull_go <= pull; end
        @(posedge clk) begin push_go <= 1'h0; pull_go <= 1'h0; end
    end
    repeat (3) @(posedge clk);
    #1;
endtask
task automatic t_defaults;
    rd(3'h1);
    `CHK(rd_val, 8'h00)
    wr(3'h7, 8'hFF);
    rd(3'h7);
    `CHK(rd_val, 8'h00)
    wr(3'h1, 8'hCE);
    rd(3'h1);
    `CHK(rd_val, 8'h00)
    $display("t_defaults done");
endtask
task automatic t_rx;
    logic [4:0] lvl [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
    logic [7:0] ch = 8'hA0;
    wr(3'h5, 8'h02);
    wr(3'h4, 8'h01);
    for (int s = 0; s < 4; s++) begin
        wr(3'h1, {s[1:0], 6'h0B});
        rd(3'h3);
        lk(lvl[s] - 1, 1'b0);
        `CHK(multi_function_pin_ff, 1'h1)
        lk(1, 1'b0);
        `CHK(multi_function_pin_ff, 1'h0)
        `CHK(irq_ff, 1'h1)
        rd(3'h3);
        `CHK(rd_val[0], 1'h1)
        lk(0, 1'b0);
        `CHK(irq_ff, 1'h0)
        repeat (lvl[s] - 1) rd(3'h0);
        `CHK(multi_function_pin_ff, 1'h0)
        rd(3'h0);
        `CHK(multi_function_pin_ff, 1'h1)
        `CHK(rd_val, ch + lvl[s] - 8'h01)
        ch = ch + {3'h0, lvl[s]};
    end
    lk(1, 1'b0);
    `CHK(multi_function_pin_ff, 1'h1)
    @(posedge clk) rx_timeout <= 1'h1;
    @(posedge clk) rx_timeout <= 1'h0;
    lk(0, 1'b0);
    `CHK(multi_function_pin_ff, 1'h0)
    `CHK(irq_ff, 1'h0)
    wr(3'h5, 8'h00);
    lk(0, 1'b0);
    `CHK(multi_function_pin_ff, 1'h1)
    rd(3'h1);
    wr(3'h1, 8'hC8);
    rd(3'h1);
    `CHK(rd_val, 8'hC8)
    wr(3'h1, 8'hCB);
    rd(3'h2);
    `CHK(rd_val[3:0], 4'h0)
    $display("t_rx done");
endtask
task automatic t_tx;
    wr(3'h1, 8'h0D);
    for (int i = 0; i < 15; i++) wr(3'h0, 8'h30 + i[7:0]);
    `CHK(tx_space_avail_n_ff, 1'h0)
    wr(3'h0, 8'h3F);
    `CHK(tx_space_avail_n_ff, 1'h1)
    lk(1, 1'b1);
    `CHK(tx_char_ff, 8'h30)
    `CHK(pulls, 1)
    `CHK(tx_space_avail_n_ff, 1'h0)
    wr(3'h1, 8'h05);
    rd(3'h2);
    `CHK(rd_val[7:4], 4'h0)
    `CHK(tx_space_avail_n_ff, 1'h0)
    wr(3'h0, 8'h55);
    `CHK(tx_space_avail_n_ff, 1'h1)
    lk(1, 1'b1);
    `CHK(tx_char_ff, 8'h55)
    `CHK(pulls, 2)
    lk(1, 1'b1);
    `CHK(pulls, 2)
    `CHK(tx_char_ff, 8'h55)
    $display("t_tx done");
endtask
initial begin
    repeat (12) @(posedge clk);
    reset <= 1'h0;
    t_defaults();
    t_rx();
    t_tx();
    finish_test();
end
endmodule
`default_nettype wire
